// ---- common/test_page_pkg.sv ----
// Purpose: constants and carrier types for the test-page register group
// Assumes: 8-bit register port, 6-bit register addresses
// Notes:   one package shared by design and bench
package test_page_pkg;

  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [5:0] ADDR_PAGE_CONTROL  = 6'h30;
  localparam logic [5:0] ADDR_PROBE_SECURE  = 6'h31;
  localparam logic [5:0] ADDR_PROBE_PRBS    = 6'h32;
  localparam logic [5:0] ADDR_DRIVER_ENABLE = 6'h33;
  localparam logic [5:0] ADDR_PIN_VALUE     = 6'h34;
  localparam logic [5:0] ADDR_PROBE_STATUS  = 6'h35;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_PAGE_CONTROL  = 8'h00;
  localparam logic [7:0] RST_PROBE_SECURE  = 8'h00;
  localparam logic [7:0] RST_PROBE_PRBS    = 8'h00;
  localparam logic [7:0] RST_DRIVER_ENABLE = 8'h80;
  localparam logic [7:0] RST_PIN_VALUE     = 8'h00;

  // ---------------------------------------------------------------
  // writable bit masks (reserved bits stay zero)
  // ---------------------------------------------------------------
  localparam logic [7:0] MASK_PAGE_CONTROL  = 8'h83;
  localparam logic [7:0] MASK_PROBE_SECURE  = 8'h3f;
  localparam logic [7:0] MASK_PROBE_PRBS    = 8'hff;
  localparam logic [7:0] MASK_DRIVER_ENABLE = 8'hff;
  localparam logic [7:0] MASK_PIN_VALUE     = 8'hff;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int PAGE_EN_BIT     = 7;
  localparam int PAGE_NUM_LSB    = 0;
  localparam int SCLK_SRC_LSB    = 4;
  localparam int SCLK_D1_BIT     = 3;
  localparam int PROBE_BIT_LSB   = 0;
  localparam int REORDER_BIT     = 7;
  localparam int PRBS9_BIT       = 6;
  localparam int PRBS15_BIT      = 5;
  localparam int PROBE_BUS_LSB   = 0;
  localparam int UART_LINES_BIT  = 7;
  localparam int GPIO_EN_BIT     = 7;
  localparam int PORT_WIDTH      = 7;
  localparam int PROBE_BUSES     = 32;
  localparam logic [6:0] SPI_PIN_MASK = 7'h1f;
  localparam logic [5:0] LOW_ADDR_MASK = 6'h0f;

  // ---------------------------------------------------------------
  // enumerations
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    SCLK_OFF  = 2'h0,
    SCLK_OSC  = 2'h1,
    SCLK_UART = 2'h2,
    SCLK_RF   = 2'h3
  } sclk_src_t;

  typedef enum logic [1:0] {
    HOST_PARALLEL = 2'h0,
    HOST_SPI      = 2'h1,
    HOST_UART     = 2'h2,
    HOST_I2C      = 2'h3
  } host_if_t;

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [5:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic [6:0] oe;
    logic [6:0] level;
  } port_drive_t;

endpackage : test_page_pkg

// ---- hdl/test_page_control_regs.sv ----
// Purpose: test-page register group: page override, secure clock, probe bus, prbs, port i/o
// Assumes: one 50 MHz clock, access strobes come from the host interface on the same clock
// Notes:   pins, probe buses and clock sources are synchronised before use
//
// Operation
// - page override on: page_number supplies address bits five and four.
// - page override off: latch address used whole, page_number ignored.
// - secure_clock_source picks off-low, oscillator, uart clock or rf clock.
// - secure_clock_on_pin_d1 drives secure clock on D1, not with parallel host.
// - probe_bit_choice picks probe bus bit driven onto signal_out_pin.
// - probe_bus_reorder maps probe bus onto pins D4,D3,D2,D6,D5,D0,D1.
// - prbs9 bit enables prbs9 generation; sending waits for transmit command.
// - prbs15 bit enables prbs15 generation; sending waits for transmit command.
// - probe_bus_choice selects which internal probe bus is observed.
// - uart_handshake_lines_enable low disables both auxiliary uart lines; resets high.
// - port_pin_drive_enable bit n enables pin Dn driver, serial host only.
// - spi, or uart with handshake lines, limits driver enables to D0-D4.
// - port_gpio_enable with serial host makes the port general i/o.
// - secure clock on D1 removes D1 from general i/o.
// - pin value read gives pin levels when gpio enabled, else stored value.
// - read-only register shows current state of chosen probe bus.
`timescale 1ns/1ps

module test_page_control_regs (
  // clock and reset
  input  wire logic                        I_CLK_SYS,
  input  wire logic                        I_SRST,
  // register access from host interface
  input  wire test_page_pkg::reg_req_t     I_REQ,
  input  wire logic [5:0]                  I_LATCH_ADDR,
  input  wire logic [3:0]                  I_PIN_ADDR,
  input  wire logic                        I_USE_PIN_ADDR,
  input  wire test_page_pkg::host_if_t     I_HOST_IF,
  output logic [7:0]                       O_RDATA,
  output logic [5:0]                       O_REG_ADDR,
  // clock sources and internal buses
  input  wire logic                        I_OSC_CLK,
  input  wire logic                        I_UART_CLK,
  input  wire logic                        I_RF_CLK,
  input  wire logic [255:0]                I_PROBE_BUSES,
  input  wire logic                        I_TX_COMMAND,
  // pins
  input  wire logic [6:0]                  I_PORT_PIN,
  output logic [6:0]                       O_PORT_PIN,
  output logic [6:0]                       O_PORT_PIN_OE,
  output logic                             O_SIGNAL_OUT,
  output logic                             O_UART_AUX_LINE_A_EN,
  output logic                             O_UART_REQUEST_LINE_EN,
  // transmitter control
  output logic                             O_PRBS9_ENABLE,
  output logic                             O_PRBS15_ENABLE,
  output logic                             O_PRBS_SEND
);

  // ---------------------------------------------------------------
  // synchronisers
  // ---------------------------------------------------------------
  logic [2:0]   clk_meta;
  logic [2:0]   clk_sync;
  logic [6:0]   pin_meta;
  logic [6:0]   pin_sync;
  logic [255:0] bus_meta;
  logic [255:0] bus_sync;

  // first stage read only by the second
  // a moving probe bus may be caught mid-change; hold it still to read it
  always_ff @(posedge I_CLK_SYS) begin
    clk_meta <= {I_RF_CLK, I_UART_CLK, I_OSC_CLK};
    clk_sync <= clk_meta;
    pin_meta <= I_PORT_PIN;
    pin_sync <= pin_meta;
    bus_meta <= I_PROBE_BUSES;
    bus_sync <= bus_meta;
  end

  // ---------------------------------------------------------------
  // register file
  // ---------------------------------------------------------------
  logic [7:0] page_control;
  logic [7:0] probe_secure;
  logic [7:0] probe_prbs;
  logic [7:0] driver_enable;
  logic [7:0] pin_value;
  logic [7:0] next_page_control;
  logic [7:0] next_probe_secure;
  logic [7:0] next_probe_prbs;
  logic [7:0] next_driver_enable;
  logic [7:0] next_pin_value;

  // masks keep reserved bits at zero on every write
  function automatic logic [7:0] masked_write(input logic [7:0] mask, input logic [7:0] data);
    masked_write = data & mask;
  endfunction : masked_write

  always_comb begin
    next_page_control  = page_control;
    next_probe_secure  = probe_secure;
    next_probe_prbs    = probe_prbs;
    next_driver_enable = driver_enable;
    next_pin_value     = pin_value;
    if (I_REQ.wr) begin
      case (I_REQ.addr)
        test_page_pkg::ADDR_PAGE_CONTROL:
          next_page_control  = masked_write(test_page_pkg::MASK_PAGE_CONTROL, I_REQ.wdata);
        test_page_pkg::ADDR_PROBE_SECURE:
          next_probe_secure  = masked_write(test_page_pkg::MASK_PROBE_SECURE, I_REQ.wdata);
        test_page_pkg::ADDR_PROBE_PRBS:
          next_probe_prbs    = masked_write(test_page_pkg::MASK_PROBE_PRBS, I_REQ.wdata);
        test_page_pkg::ADDR_DRIVER_ENABLE:
          next_driver_enable = masked_write(test_page_pkg::MASK_DRIVER_ENABLE, I_REQ.wdata);
        test_page_pkg::ADDR_PIN_VALUE:
          next_pin_value     = masked_write(test_page_pkg::MASK_PIN_VALUE, I_REQ.wdata);
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (I_SRST) begin
      page_control  <= test_page_pkg::RST_PAGE_CONTROL;
      probe_secure  <= test_page_pkg::RST_PROBE_SECURE;
      probe_prbs    <= test_page_pkg::RST_PROBE_PRBS;
      driver_enable <= test_page_pkg::RST_DRIVER_ENABLE;
      pin_value     <= test_page_pkg::RST_PIN_VALUE;
    end else begin
      page_control  <= next_page_control;
      probe_secure  <= next_probe_secure;
      probe_prbs    <= next_probe_prbs;
      driver_enable <= next_driver_enable;
      pin_value     <= next_pin_value;
    end
  end

  // ---------------------------------------------------------------
  // decoded fields
  // ---------------------------------------------------------------
  logic                         page_override_enable;
  logic [1:0]                   page_number;
  test_page_pkg::sclk_src_t     secure_clock_source;
  logic                         secure_clock_on_pin_d1;
  logic [2:0]                   probe_bit_choice;
  logic                         probe_bus_reorder;
  logic [4:0]                   probe_bus_choice;
  logic                         uart_handshake_lines_enable;
  logic [6:0]                   port_pin_drive_enable;
  logic                         port_gpio_enable;
  logic [6:0]                   port_pin_level;
  logic                         serial_host;

  assign page_override_enable        = page_control[test_page_pkg::PAGE_EN_BIT];
  assign page_number                 = page_control[test_page_pkg::PAGE_NUM_LSB +: 2];
  assign secure_clock_source         = test_page_pkg::sclk_src_t'(probe_secure[test_page_pkg::SCLK_SRC_LSB +: 2]);
  assign secure_clock_on_pin_d1      = probe_secure[test_page_pkg::SCLK_D1_BIT];
  assign probe_bit_choice            = probe_secure[test_page_pkg::PROBE_BIT_LSB +: 3];
  assign probe_bus_reorder           = probe_prbs[test_page_pkg::REORDER_BIT];
  assign probe_bus_choice            = probe_prbs[test_page_pkg::PROBE_BUS_LSB +: 5];
  assign uart_handshake_lines_enable = driver_enable[test_page_pkg::UART_LINES_BIT];
  assign port_pin_drive_enable       = driver_enable[6:0];
  assign port_gpio_enable            = pin_value[test_page_pkg::GPIO_EN_BIT];
  assign port_pin_level              = pin_value[6:0];
  assign serial_host                 = (I_HOST_IF != test_page_pkg::HOST_PARALLEL);

  // ---------------------------------------------------------------
  // address formation, secure clock, probe bus, port
  // ---------------------------------------------------------------
  logic [7:0]  probe_word;
  logic [5:0]  low_addr;
  logic [5:0]  next_reg_addr;
  logic        next_secure_clk;
  logic        next_signal_out;
  logic [6:0]  allowed_pins;
  logic [6:0]  next_pin_oe;
  logic [6:0]  next_pin_out;
  logic [7:0]  next_rdata;
  logic        clk_on_d1;
  logic [7:0]  next_rdata_out;

  always_comb begin
    probe_word = bus_sync[{probe_bus_choice, 3'h0} +: 8];
    low_addr   = I_USE_PIN_ADDR ? {2'h0, I_PIN_ADDR} : I_LATCH_ADDR;
    if (page_override_enable)
      next_reg_addr = {page_number, low_addr[3:0]};
    else
      next_reg_addr = I_LATCH_ADDR;
  end

  // ---------------------------------------------------------------
  // secure clock
  // ---------------------------------------------------------------
  // sources are only sampled here, so the copy on D1 is coarse and jittery
  always_comb begin
    case (secure_clock_source)
      test_page_pkg::SCLK_OFF:  next_secure_clk = 1'b0;
      test_page_pkg::SCLK_OSC:  next_secure_clk = clk_sync[0];
      test_page_pkg::SCLK_UART: next_secure_clk = clk_sync[1];
      test_page_pkg::SCLK_RF:   next_secure_clk = clk_sync[2];
      default:                  next_secure_clk = 1'b0;
    endcase
  end

  // ---------------------------------------------------------------
  // signal out
  // ---------------------------------------------------------------
  always_comb begin
    next_signal_out = probe_word[probe_bit_choice];
  end

  // ---------------------------------------------------------------
  // pin drive
  // ---------------------------------------------------------------
  // reorder wins over port i/o so a probe word reaches every pin except D1 while the secure clock is on D1
  always_comb begin
    clk_on_d1 = secure_clock_on_pin_d1 && serial_host;
    // spi or uart with handshake lines leaves only D0-D4
    if (I_HOST_IF == test_page_pkg::HOST_SPI ||
        (I_HOST_IF == test_page_pkg::HOST_UART && uart_handshake_lines_enable))
      allowed_pins = test_page_pkg::SPI_PIN_MASK;
    else
      allowed_pins = 7'h7f;
    next_pin_oe  = 7'h00;
    next_pin_out = 7'h00;
    if (probe_bus_reorder) begin
      next_pin_oe  = 7'h7f;
      next_pin_out = {probe_word[3], probe_word[4], probe_word[0], probe_word[1],
                      probe_word[2], probe_word[6], probe_word[5]};
    end else if (serial_host) begin
      next_pin_oe  = port_pin_drive_enable & allowed_pins;
      next_pin_out = port_gpio_enable ? port_pin_level : 7'h00;
    end
    if (clk_on_d1) begin
      next_pin_oe[1]  = 1'b1;
      next_pin_out[1] = next_secure_clk;
    end
  end

  // ---------------------------------------------------------------
  // read data
  // ---------------------------------------------------------------
  // only mapped registers answer; anything else reads as zero
  always_comb begin
    case (I_REQ.addr)
      test_page_pkg::ADDR_PAGE_CONTROL:  next_rdata = page_control;
      test_page_pkg::ADDR_PROBE_SECURE:  next_rdata = probe_secure;
      test_page_pkg::ADDR_PROBE_PRBS:    next_rdata = probe_prbs;
      test_page_pkg::ADDR_DRIVER_ENABLE: next_rdata = driver_enable;
      test_page_pkg::ADDR_PIN_VALUE:
        next_rdata = port_gpio_enable ? {1'b1, pin_sync} : pin_value;
      test_page_pkg::ADDR_PROBE_STATUS:  next_rdata = probe_word;
      default:                           next_rdata = 8'h00;
    endcase
    // idle cycles read as zero so a stale word is never taken for data
    next_rdata_out = I_REQ.rd ? next_rdata : 8'h00;
  end

  // ---------------------------------------------------------------
  // transmitter control
  // ---------------------------------------------------------------
  logic        next_prbs9;
  logic        next_prbs15;
  logic        next_prbs_send;

  // a bare command with no prbs mode chosen leaves the transmitter alone
  always_comb begin
    next_prbs9     = probe_prbs[test_page_pkg::PRBS9_BIT];
    next_prbs15    = probe_prbs[test_page_pkg::PRBS15_BIT];
    next_prbs_send = I_TX_COMMAND && (next_prbs9 || next_prbs15);
  end

  // ---------------------------------------------------------------
  // output registers
  // ---------------------------------------------------------------
  // prbs enables follow the bits; sending is gated by the transmit command
  always_ff @(posedge I_CLK_SYS) begin
    if (I_SRST) begin
      O_RDATA                <= 8'h00;
      O_REG_ADDR             <= 6'h00;
      O_PORT_PIN             <= 7'h00;
      O_PORT_PIN_OE          <= 7'h00;
      O_SIGNAL_OUT           <= 1'b0;
      O_UART_AUX_LINE_A_EN   <= 1'b1;
      O_UART_REQUEST_LINE_EN <= 1'b1;
      O_PRBS9_ENABLE         <= 1'b0;
      O_PRBS15_ENABLE        <= 1'b0;
      O_PRBS_SEND            <= 1'b0;
    end else begin
      O_RDATA                <= next_rdata_out;
      O_REG_ADDR             <= next_reg_addr;
      O_PORT_PIN             <= next_pin_out;
      O_PORT_PIN_OE          <= next_pin_oe;
      O_SIGNAL_OUT           <= next_signal_out;
      O_UART_AUX_LINE_A_EN   <= uart_handshake_lines_enable;
      O_UART_REQUEST_LINE_EN <= uart_handshake_lines_enable;
      O_PRBS9_ENABLE         <= next_prbs9;
      O_PRBS15_ENABLE        <= next_prbs15;
      O_PRBS_SEND            <= next_prbs_send;
    end
  end

endmodule : test_page_control_regs

// ---- verification/test_page_checker.sv ----
// Purpose: port assertions for the test-page registers
// Assumes: shadow copies track host writes
// Notes:   synced pin and probe values are left to the bench
`timescale 1ns/1ps
module test_page_checker (
  // clock, reset, host side
  input wire logic                    I_CLK_SYS,
  input wire logic                    I_SRST,
  input wire test_page_pkg::reg_req_t I_REQ,
  input wire logic [5:0]              I_LATCH_ADDR,
  input wire logic [3:0]              I_PIN_ADDR,
  input wire logic                    I_USE_PIN_ADDR,
  input wire test_page_pkg::host_if_t I_HOST_IF,
  input wire logic                    I_TX_COMMAND,
  // observed outputs
  input wire logic [7:0]              O_RDATA,
  input wire logic [5:0]              O_REG_ADDR,
  input wire logic [6:0]              O_PORT_PIN,
  input wire logic [6:0]              O_PORT_PIN_OE,
  input wire logic                    O_UART_AUX_LINE_A_EN,
  input wire logic                    O_UART_REQUEST_LINE_EN,
  input wire logic                    O_PRBS9_ENABLE,
  input wire logic                    O_PRBS15_ENABLE,
  input wire logic                    O_PRBS_SEND
);
  // ------------------------------------------
  // register shadow
  // ------------------------------------------
  localparam logic [7:0] MSK [5] = '{8'h83, 8'h3f, 8'hff, 8'hff, 8'hff};
  logic [7:0] sh [5];
  logic [7:0] next_sh [5];
  logic [6:0] allow, exp_oe, exp_lvl;
  logic [5:0] exp_addr;
  logic [7:0] rd_exp;
  logic [1:0] prbs;
  logic       lines, plain, flip;
  always_comb begin
    next_sh = sh;
    if (I_REQ.wr && I_REQ.addr inside {[6'h30:6'h34]})
      next_sh[I_REQ.addr[2:0]] = I_REQ.wdata & MSK[I_REQ.addr[2:0]];
  end
  always_ff @(posedge I_CLK_SYS) begin
    if (I_SRST)
      sh <= '{8'h00, 8'h00, 8'h00, 8'h80, 8'h00};
    else
      sh <= next_sh;
  end
  always_comb begin
    allow = (I_HOST_IF == test_page_pkg::HOST_SPI || (I_HOST_IF == test_page_pkg::HOST_UART && sh[3][7])) ? 7'h1f : 7'h7f;
    exp_oe = (I_HOST_IF == test_page_pkg::HOST_PARALLEL) ? 7'h00 : sh[3][6:0] & allow;
    exp_lvl = sh[4][7] ? sh[4][6:0] & exp_oe : 7'h00;
    exp_addr = sh[0][7] ? {sh[0][1:0], I_USE_PIN_ADDR ? I_PIN_ADDR : I_LATCH_ADDR[3:0]} : I_LATCH_ADDR;
    rd_exp = I_REQ.addr[2] ? sh[4] : sh[I_REQ.addr[1:0]];
    prbs = sh[2][6:5];
    lines = sh[3][7];
    flip = sh[2][7];
    plain = !flip && !sh[1][3];
  end
  // ------------------------------------------
  // properties
  // ------------------------------------------
  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (I_SRST);
  // outputs are forced during reset, so relations start one edge later
  sequence after_run; !$past(I_SRST); endsequence
  sequence rd_stored; I_REQ.rd && (I_REQ.addr inside {[6'h30:6'h33]} || (I_REQ.addr == 6'h34 && !sh[4][7])); endsequence
  sequence send_cmd; I_TX_COMMAND && prbs != 2'b00; endsequence
  AST_REG_ADDR: assert property (after_run |-> O_REG_ADDR == $past(exp_addr))
    else $error("effective register address wrong");
  AST_PRBS_LEVEL: assert property (after_run |-> {O_PRBS9_ENABLE, O_PRBS15_ENABLE} == $past(prbs))
    else $error("prbs enables do not follow register");
  AST_PRBS_SEND: assert property (send_cmd |=> O_PRBS_SEND) else $error("send missing");
  AST_PRBS_HOLD: assert property (!I_TX_COMMAND |=> !O_PRBS_SEND) else $error("send without command");
  AST_UART_LINES: assert property (after_run |-> {O_UART_AUX_LINE_A_EN, O_UART_REQUEST_LINE_EN} == {2{$past(lines)}})
    else $error("aux uart enables wrong");
  AST_READ_BACK: assert property (rd_stored |=> O_RDATA == $past(rd_exp)) else $error("read data wrong");
  AST_READ_UNMAPPED: assert property (I_REQ.rd && !(I_REQ.addr inside {[6'h30:6'h35]}) |=> O_RDATA == 8'h00)
    else $error("unmapped read not zero");
  AST_PORT_OE: assert property (after_run ##0 $past(plain) |-> O_PORT_PIN_OE == $past(exp_oe))
    else $error("pin enables wrong");
  AST_PORT_LEVEL: assert property (after_run ##0 $past(plain) |-> (O_PORT_PIN & $past(exp_oe)) == $past(exp_lvl))
    else $error("pin levels wrong");
  AST_REORDER_OE: assert property (after_run ##0 $past(flip) |-> O_PORT_PIN_OE == 7'h7f)
    else $error("reorder leaves pins undriven");
endmodule : test_page_checker

// ---- verification/tb_test_page_control_regs.sv ----
// Purpose: self-checking bench for test_page_control_regs
// Assumes: 50 MHz clock, inputs driven on the falling edge
// Notes:   waits of six cycles cover the two-flop input sync
`timescale 1ns/1ps
module tb_test_page_control_regs;
  // ------------------------------------------
  // signals
  // ------------------------------------------
  localparam logic [7:0] MSK [5] = '{8'h83, 8'h3f, 8'hff, 8'hff, 8'hff};
  localparam logic [7:0] RST [5] = '{8'h00, 8'h00, 8'h00, 8'h80, 8'h00};
  logic                    clk = 1'b0;
  logic                    srst = 1'b1;
  test_page_pkg::reg_req_t req = '0;
  test_page_pkg::host_if_t host = test_page_pkg::HOST_PARALLEL;
  logic [5:0]              latch = '0;
  logic [3:0]              pin_addr = '0;
  logic                    use_pin = 1'b0, osc = 1'b0, uclk = 1'b0, rf = 1'b0, tx = 1'b0;
  logic [255:0]            probes = '0;
  logic [6:0]              pins_in = '0;
  logic [7:0]              rdata, v, w, u;
  logic [5:0]              reg_addr;
  logic [6:0]              pin_out, pin_oe;
  logic                    sig_out, aux_en, req_en, p9, p15, send;
  int                      n_errors = 0, comparisons = 0, seed = 32'ha43d, k, b;
  test_page_control_regs test_page_control_regs_i (.I_CLK_SYS(clk), .I_SRST(srst), .I_REQ(req),
    .I_LATCH_ADDR(latch), .I_PIN_ADDR(pin_addr), .I_USE_PIN_ADDR(use_pin), .I_HOST_IF(host),
    .O_RDATA(rdata), .O_REG_ADDR(reg_addr), .I_OSC_CLK(osc), .I_UART_CLK(uclk), .I_RF_CLK(rf),
    .I_PROBE_BUSES(probes), .I_TX_COMMAND(tx), .I_PORT_PIN(pins_in), .O_PORT_PIN(pin_out),
    .O_PORT_PIN_OE(pin_oe), .O_SIGNAL_OUT(sig_out), .O_UART_AUX_LINE_A_EN(aux_en),
    .O_UART_REQUEST_LINE_EN(req_en), .O_PRBS9_ENABLE(p9), .O_PRBS15_ENABLE(p15), .O_PRBS_SEND(send));
  // ------------------------------------------
  // helpers
  // ------------------------------------------
  initial forever #10 clk = ~clk;
  function automatic logic [6:0] oe_exp(input test_page_pkg::host_if_t h, input logic [7:0] e);
    if (h == test_page_pkg::HOST_PARALLEL) return 7'h00;
    if (h == test_page_pkg::HOST_SPI || (h == test_page_pkg::HOST_UART && e[7])) return e[6:0] & 7'h1f;
    return e[6:0];
  endfunction : oe_exp
  function automatic logic [6:0] flip_exp(input logic [7:0] t);
    return {t[3], t[4], t[0], t[1], t[2], t[6], t[5]};
  endfunction : flip_exp
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(negedge clk);
    req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge clk);
    req = '0;
  endtask : wr
  // data stands one cycle, so it is taken at the next falling edge
  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    @(negedge clk);
    req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(negedge clk);
    req = '0;
    d = rdata;
  endtask : rd
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : end_of_test
  initial begin
    repeat (5000) @(posedge clk);
    n_errors++;
    end_of_test();
  end
  // ------------------------------------------
  // tests
  // ------------------------------------------
  initial begin
    repeat (4) @(negedge clk);
    srst = 1'b0;
    chk("aux lines", 8'h03, {6'h00, aux_en, req_en});
    for (k = 0; k < 5; k++) begin
      rd(6'(6'h30 + k), v);
      chk("reset value", RST[k], v);
    end
    for (k = 0; k < 24; k++) begin
      b = k % 5;
      w = (k == 20) ? 8'hff : 8'($random(seed)) & ((b == 4) ? 8'h7f : 8'hff);
      wr(6'(6'h30 + b), w);
      rd(6'(6'h30 + b), v);
      chk("readback", w & MSK[b], v);
    end
    pins_in = 7'($random(seed));
    wr(6'h34, 8'h80);
    repeat (4) @(negedge clk);
    rd(6'h34, v);
    chk("pin read", {1'b1, pins_in}, v);
    rd(6'h3c, v);
    chk("unmapped", 8'h00, v);
    $display("test registers done");
    for (k = 0; k < 8; k++) begin
      w = 8'($random(seed));
      {use_pin, pin_addr, latch} = 11'($random(seed));
      wr(6'h30, w);
      @(negedge clk);
      chk("reg addr", {2'b00, w[7] ? {w[1:0], use_pin ? pin_addr : latch[3:0]} : latch}, {2'b00, reg_addr});
    end
    $display("test page done");
    host = test_page_pkg::HOST_I2C;
    for (k = 0; k < 10; k++) begin
      probes = {8{32'($random(seed))}};
      u = 8'($random(seed));
      u[7] = k[0];
      w = 8'($random(seed));
      wr(6'h31, {5'h00, w[2:0]});
      wr(6'h32, {u[7], 2'b00, u[4:0]});
      wr(6'h35, ~u);
      repeat (6) @(negedge clk);
      b = 8 * int'(u[4:0]);
      chk("signal out", {7'h00, probes[b + int'(w[2:0])]}, {7'h00, sig_out});
      rd(6'h35, v);
      chk("probe status", probes[b+:8], v);
      if (u[7]) chk("reorder", {1'b0, flip_exp(probes[b+:8])}, {1'b0, pin_out & pin_oe});
    end
    $display("test probe done");
    wr(6'h32, 8'h00);
    wr(6'h31, 8'h00);
    for (k = 0; k < 16; k++) begin
      host = test_page_pkg::host_if_t'(2'(k));
      w = 8'($random(seed));
      u = 8'($random(seed));
      wr(6'h33, w);
      wr(6'h34, u);
      @(negedge clk);
      chk("pin enable", {1'b0, oe_exp(host, w)}, {1'b0, pin_oe});
      chk("pin level", {1'b0, u[7] ? u[6:0] & oe_exp(host, w) : 7'h00}, {1'b0, pin_out & pin_oe});
    end
    $display("test port done");
    wr(6'h33, 8'h7f);
    wr(6'h34, 8'h80);
    for (k = 0; k < 16; k++) begin
      host = (k < 8) ? test_page_pkg::HOST_UART : test_page_pkg::HOST_PARALLEL;
      b = k / 2 % 4;
      u[2:0] = 3'((4'h1 << b) >> 1);
      {rf, uclk, osc} = k[0] ? ~u[2:0] : u[2:0];
      wr(6'h31, {2'b00, 2'(b), 4'h8});
      repeat (6) @(negedge clk);
      chk("secure clock", {6'h00, k < 8, k < 8 && !k[0] && b != 0}, {6'h00, pin_oe[1], pin_out[1] & pin_oe[1]});
    end
    $display("test secure clock done");
    for (k = 0; k < 4; k++) begin
      wr(6'h32, 8'(k << 5));
      @(negedge clk);
      tx = 1'b1;
      @(negedge clk);
      tx = 1'b0;
      chk("prbs", {5'h00, 2'(k), k != 0}, {5'h00, p9, p15, send});
    end
    wr(6'h33, 8'h00);
    @(negedge clk);
    chk("aux lines off", 8'h00, {6'h00, aux_en, req_en});
    $display("test prbs done");
    end_of_test();
  end
endmodule : tb_test_page_control_regs
bind test_page_control_regs test_page_checker test_page_checker_i (.I_CLK_SYS, .I_SRST, .I_REQ, .I_LATCH_ADDR,
  .I_PIN_ADDR, .I_USE_PIN_ADDR, .I_HOST_IF, .I_TX_COMMAND, .O_RDATA, .O_REG_ADDR, .O_PORT_PIN, .O_PORT_PIN_OE,
  .O_UART_AUX_LINE_A_EN, .O_UART_REQUEST_LINE_EN, .O_PRBS9_ENABLE, .O_PRBS15_ENABLE, .O_PRBS_SEND);
